/* File: core/fic_fault_ctrl.v */
// Interrupt output and fault power-down control with its three configuration registers
`timescale 1ns/1ps
`include "fic_map.vh"
module fic_fault_ctrl #(
  parameter NFLAG = 8,
  parameter PULSE_CYC = `FIC_PULSE_CYC,
  parameter PERIOD_CYC = `FIC_PERIOD_CYC
) (
  input wire mclk,
  input wire resetn,
  input wire clk_en,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  input wire flag_rd,
  output reg [NFLAG-1:0] flag_rdata,
  output reg [NFLAG-1:0] live_flags,
  input wire [NFLAG-1:0] event_src,
  input wire [NFLAG-1:0] irq_mask,
  input wire [NFLAG-1:0] adc_fault_sel,
  input wire [NFLAG-1:0] dac_fault_sel,
  input wire driver_gate_fault,
  input wire output_short_fault,
  input wire regulator_short,
  input wire dac_powering_up,
  input wire ch1_in_recovery,
  input wire ch2_in_recovery,
  input wire adc_repower,
  input wire dac_repower,
  output reg interrupt_line_low,
  output reg adc_fault_pd,
  output reg dac_fault_pd,
  output reg output_fault_detect_off,
  output reg regulator_short_detect_off,
  output reg ch1_mute,
  output reg ch2_mute
);

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  reg [7:0] interrupt_config;
  reg [7:0] output_fault_config;
  reg [7:0] overload_mute_config;

  wire irq_polarity_sel = interrupt_config[`FIC_POL_BIT];
  wire [1:0] irq_event_sel = interrupt_config[`FIC_EVT_HI:`FIC_EVT_LO];
  wire [1:0] adc_fault_powerdown_sel = interrupt_config[`FIC_APD_HI:`FIC_APD_LO];
  wire latch_readback_filter = interrupt_config[`FIC_RDFILT_BIT];
  wire adc_fault_recovery_sel = interrupt_config[`FIC_ARCV_BIT];
  wire latch_clear_policy = interrupt_config[`FIC_CLRPOL_BIT];
  wire [1:0] output_fault_powerdown_sel = output_fault_config[`FIC_DPD_HI:`FIC_DPD_LO];
  wire output_fault_recovery_sel = output_fault_config[`FIC_DRCV_BIT];
  wire startup_fault_pd_inhibit = output_fault_config[`FIC_SUINH_BIT];
  wire detect_off_cfg = output_fault_config[`FIC_DDET_BIT];
  wire reg_detect_off_cfg = output_fault_config[`FIC_RDET_BIT];
  wire ch1_overload_mute = overload_mute_config[`FIC_M1_BIT];
  wire ch2_overload_mute = overload_mute_config[`FIC_M2_BIT];

  // ----------------------------------------
  // Interrupt event modes
  // ----------------------------------------
  localparam [1:0] MODE_LATCHED = 2'h0;
  localparam [1:0] MODE_LIVE = 2'h1;
  localparam [1:0] MODE_PERIODIC = 2'h2;
  localparam [1:0] MODE_ONE_SHOT = 2'h3;

  // Mode decode kept apart so the timer sees clean single-bit selects
  wire periodic_mode = (irq_event_sel == MODE_PERIODIC);
  wire one_shot_mode = (irq_event_sel == MODE_ONE_SHOT);

  // ----------------------------------------
  // Synchronise the analog-side inputs
  // ----------------------------------------
  localparam NSYNC = NFLAG + 6;
  wire [NSYNC-1:0] raw_in = {event_src, driver_gate_fault, output_short_fault,
    regulator_short, dac_powering_up, ch1_in_recovery, ch2_in_recovery};
  reg [NSYNC-1:0] sync_a;
  reg [NSYNC-1:0] sync_b;

  // First stage is read only by the second stage
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sync_a <= {NSYNC{1'b0}};
      sync_b <= {NSYNC{1'b0}};
    end else if (clk_en) begin
      sync_a <= raw_in;
      sync_b <= sync_a;
    end
  end

  // Logic taps only the second stage
  wire [NFLAG-1:0] ev_s = sync_b[NSYNC-1:6];
  wire gate_s = sync_b[5];
  wire short_s = sync_b[4];
  wire reg_s = sync_b[3];
  wire pwrup_s = sync_b[2];
  wire rec1_s = sync_b[1];
  wire rec2_s = sync_b[0];

  // ----------------------------------------
  // Fault qualification
  // ----------------------------------------
  // Gate fault during DAC start-up may be ignored for power-down only
  wire gate_q = gate_s && !detect_off_cfg;
  wire short_q = short_s && !detect_off_cfg;
  wire reg_q = reg_s && !reg_detect_off_cfg;
  wire gate_pd = gate_q && !(startup_fault_pd_inhibit && pwrup_s);

  // ----------------------------------------
  // Live and latched flags
  // ----------------------------------------
  reg [NFLAG-1:0] latched_flags;
  reg [NFLAG-1:0] live_prev;
  wire [NFLAG-1:0] unmasked = ~irq_mask;
  wire [NFLAG-1:0] rise = ev_s & ~live_prev;
  wire flag_read = flag_rd && clk_en;

  // Policy 0 refuses the clear while the condition is still live; policy 1 clears anyway
  wire [NFLAG-1:0] clear_ok = {NFLAG{flag_read}} & ({NFLAG{latch_clear_policy}} | ~ev_s);

  genvar gi;
  generate
    for (gi = 0; gi < NFLAG; gi = gi + 1) begin : g_flag
      // Set wins over a same-cycle read clear so no event is lost
      always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
          latched_flags[gi] <= 1'b0;
        end else if (clk_en) begin
          if (rise[gi]) begin
            latched_flags[gi] <= 1'b1;
          end else if (clear_ok[gi]) begin
            latched_flags[gi] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // Live copy follows the condition; the edge reference shares its timing
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      live_prev <= {NFLAG{1'b0}};
      live_flags <= {NFLAG{1'b0}};
    end else if (clk_en) begin
      live_prev <= ev_s;
      live_flags <= ev_s;
    end
  end

  // Readback snapshot is taken with the pre-clear flags of the same edge
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      flag_rdata <= {NFLAG{1'b0}};
    end else if (flag_read) begin
      flag_rdata <= latch_readback_filter ? (latched_flags & unmasked) : latched_flags;
    end
  end

  // ----------------------------------------
  // Interrupt waveform
  // ----------------------------------------
  wire any_latched = |(latched_flags & unmasked);
  wire any_live = |(ev_s & unmasked);
  wire any_rise = |(rise & unmasked);
  wire pulse_active;

  // One timer serves both pulse modes; it only starts while one of them is selected
  fic_pulse_timer #(
    .PULSE_CYC(PULSE_CYC),
    .PERIOD_CYC(PERIOD_CYC),
    .CW(32)
  ) u_timer (
    .mclk(mclk),
    .resetn(resetn),
    .clk_en(clk_en),
    .periodic(periodic_mode),
    .request(any_latched),
    .trigger(any_rise && one_shot_mode),
    .active(pulse_active)
  );

  reg irq_assert;
  // Mode mux in front of the polarity stage
  always @* begin
    case (irq_event_sel)
      MODE_LATCHED: irq_assert = any_latched;
      MODE_LIVE: irq_assert = any_live;
      MODE_PERIODIC: irq_assert = pulse_active;
      MODE_ONE_SHOT: irq_assert = pulse_active;
      default: irq_assert = 1'b0;
    endcase
  end

  // Polarity applied after the mode mux; reset level suits the default active-low pin
  wire irq_level = irq_polarity_sel ? irq_assert : !irq_assert;

  // Output level: polarity 0 drives low when asserted
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      interrupt_line_low <= 1'b1;
    end else if (clk_en) begin
      interrupt_line_low <= irq_level;
    end
  end

  // ----------------------------------------
  // Fault power-down
  // ----------------------------------------
  wire [NFLAG-1:0] adc_faults = ev_s & adc_fault_sel;
  wire [NFLAG-1:0] dac_faults = ev_s & dac_fault_sel;
  reg adc_trip;
  reg dac_trip;

  // Reserved select 3 treated as no power-down
  always @* begin
    case (adc_fault_powerdown_sel)
      `FIC_PD_UNMASKED: adc_trip = |(adc_faults & unmasked) || reg_q;
      `FIC_PD_ALL: adc_trip = (|adc_faults) || reg_q;
      default: adc_trip = 1'b0;
    endcase
  end

  // Gate and short faults count against the DAC whatever the mask says
  always @* begin
    case (output_fault_powerdown_sel)
      `FIC_PD_UNMASKED: dac_trip = |(dac_faults & unmasked) || gate_pd || short_q;
      `FIC_PD_ALL: dac_trip = (|dac_faults) || gate_pd || short_q;
      default: dac_trip = 1'b0;
    endcase
  end

  // Auto recovery follows the fault; manual holds until software repowers
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      adc_fault_pd <= 1'b0;
    end else if (clk_en) begin
      if (adc_trip) begin
        adc_fault_pd <= 1'b1;
      end else if (!adc_fault_recovery_sel || adc_repower) begin
        adc_fault_pd <= 1'b0;
      end
    end
  end

  // DAC recovery is manual out of reset, so a fault stays visible until released
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      dac_fault_pd <= 1'b0;
    end else if (clk_en) begin
      if (dac_trip) begin
        dac_fault_pd <= 1'b1;
      end else if (!output_fault_recovery_sel || dac_repower) begin
        dac_fault_pd <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Overload mute and detect enables
  // ----------------------------------------
  // Mute only while the converter itself reports recovery; no hold-off is added
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ch1_mute <= 1'b0;
      ch2_mute <= 1'b0;
    end else if (clk_en) begin
      ch1_mute <= ch1_overload_mute && rec1_s;
      ch2_mute <= ch2_overload_mute && rec2_s;
    end
  end

  // Detect enables reach the analog side one cycle after the write
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      output_fault_detect_off <= 1'b0;
      regulator_short_detect_off <= 1'b0;
    end else if (clk_en) begin
      output_fault_detect_off <= detect_off_cfg;
      regulator_short_detect_off <= reg_detect_off_cfg;
    end
  end

  // ----------------------------------------
  // Register port
  // ----------------------------------------
  // One strobe per register keeps each write path a plain enable
  wire wr_int_cfg = clk_en && reg_wr && (reg_addr == `FIC_ADDR_INT_CFG);
  wire wr_out_flt = clk_en && reg_wr && (reg_addr == `FIC_ADDR_OUT_FLT);
  wire wr_ovl_mute = clk_en && reg_wr && (reg_addr == `FIC_ADDR_OVL_MUTE);

  // Every bit of the interrupt configuration is writable
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      interrupt_config <= `FIC_RST_INT_CFG;
    end else if (wr_int_cfg) begin
      interrupt_config <= reg_wdata;
    end
  end

  // Read-only bits ignore writes so reserved bits stay at reset value
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      output_fault_config <= `FIC_RST_OUT_FLT;
    end else if (wr_out_flt) begin
      output_fault_config <= reg_wdata & `FIC_WMASK_OUT_FLT;
    end
  end

  // Upper reserved bits are plain storage; the low three always read zero
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      overload_mute_config <= `FIC_RST_OVL_MUTE;
    end else if (wr_ovl_mute) begin
      overload_mute_config <= reg_wdata & `FIC_WMASK_OVL_MUTE;
    end
  end

  // ----------------------------------------
  // Register reads
  // ----------------------------------------
  // Read data registered one cycle after the strobe; unmapped reads zero
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else if (clk_en && reg_rd) begin
      case (reg_addr)
        `FIC_ADDR_INT_CFG: reg_rdata <= interrupt_config;
        `FIC_ADDR_OUT_FLT: begin
          reg_rdata <= output_fault_config;
          reg_rdata[`FIC_DOFF_BIT] <= dac_fault_pd;
        end
        `FIC_ADDR_OVL_MUTE: reg_rdata <= overload_mute_config;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

endmodule

/* File: core/fic_map.vh */
// Register map, field positions, reset values and timing counts for the fault interrupt control
//
// Contract
// - Interrupt line is active low when polarity bit is 0, active high when 1.
// - Event mode 0 holds interrupt asserted while any unmasked latched flag is set.
// - Event mode 1 asserts interrupt following unmasked live conditions, not latched flags.
// - Event mode 2 asserts about 2 ms every 4 ms while unmasked latched flag set.
// - Event mode 3 emits one 2 ms pulse per unmasked interrupt event; the timer ignores events that rise while a pulse is running.
// - Two-bit ADC/mic-bias fault power-down select: none, unmasked only, all; 3 reserved.
// - Readback filter 0 shows all latched flags, 1 shows only unmasked ones.
// - ADC recovery 0 re-powers channels once fault clears; 1 keeps them down.
// - Clear policy 0 clears flag on read only when live is zero; 1 always.
// - Two-bit DAC fault power-down select, reset 10b: none, unmasked, all; 3 reserved.
// - DAC recovery 0 re-powers automatically; 1, the reset value, keeps DAC off.
// - Read-only status bit shows any DAC channel powered down by a fault.
// - Startup inhibit 1 ignores driver gate fault during DAC power-up; 0 powers down.
// - Detect-disable 1 suppresses DAC driver gate and short faults; 0 detects them.
// - Regulator detect-disable 1 suppresses regulator short detection; 0 detects it.
// - Channel 1 overload-mute bit mutes ADC channel 1 during its overload recovery.
// - Channel 2 overload-mute bit mutes ADC channel 2 during its overload recovery.
`ifndef FIC_MAP_VH
`define FIC_MAP_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define FIC_ADDR_INT_CFG 8'h42
`define FIC_ADDR_OUT_FLT 8'h43
`define FIC_ADDR_OVL_MUTE 8'h4b

// ----------------------------------------
// Reset values and writable masks
// ----------------------------------------
`define FIC_RST_INT_CFG 8'h00
`define FIC_RST_OUT_FLT 8'h50
`define FIC_RST_OVL_MUTE 8'h00
`define FIC_WMASK_OUT_FLT 8'h77
`define FIC_WMASK_OVL_MUTE 8'hf8

// ----------------------------------------
// Field positions
// ----------------------------------------
`define FIC_POL_BIT 7
`define FIC_EVT_HI 6
`define FIC_EVT_LO 5
`define FIC_APD_HI 4
`define FIC_APD_LO 3
`define FIC_RDFILT_BIT 2
`define FIC_ARCV_BIT 1
`define FIC_CLRPOL_BIT 0
`define FIC_DPD_HI 6
`define FIC_DPD_LO 5
`define FIC_DRCV_BIT 4
`define FIC_DOFF_BIT 3
`define FIC_SUINH_BIT 2
`define FIC_DDET_BIT 1
`define FIC_RDET_BIT 0
`define FIC_M1_BIT 4
`define FIC_M2_BIT 3

// ----------------------------------------
// Encodings of the fault power-down selects
// ----------------------------------------
`define FIC_PD_NONE 2'h0
`define FIC_PD_UNMASKED 2'h1
`define FIC_PD_ALL 2'h2

// ----------------------------------------
// Timing: pulse width and period in microseconds
// ----------------------------------------
`define FIC_CLK_MHZ 50
`define FIC_PULSE_US 2000
`define FIC_PERIOD_US 4000
`define FIC_PULSE_CYC (`FIC_PULSE_US * `FIC_CLK_MHZ)
`define FIC_PERIOD_CYC (`FIC_PERIOD_US * `FIC_CLK_MHZ)

`endif

/* File: core/fic_pulse_timer.v */
// Pulse timer that drives the periodic and one-shot interrupt waveforms
`timescale 1ns/1ps
module fic_pulse_timer #(
  parameter PULSE_CYC = 100000,
  parameter PERIOD_CYC = 200000,
  parameter CW = 18
) (
  input wire mclk,
  input wire resetn,
  input wire clk_en,
  input wire periodic,
  input wire request,
  input wire trigger,
  output reg active
);

  // ----------------------------------------
  // Counter
  // ----------------------------------------
  reg [CW-1:0] count;
  reg running;
  wire [CW-1:0] pulse_end = PULSE_CYC[CW-1:0] - {{(CW-1){1'b0}}, 1'b1};
  wire [CW-1:0] period_end = PERIOD_CYC[CW-1:0] - {{(CW-1){1'b0}}, 1'b1};

  // Periodic mode restarts each period while requested; one-shot runs a single pulse
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      count <= {CW{1'b0}};
      running <= 1'b0;
      active <= 1'b0;
    end else if (clk_en) begin
      if (!running) begin
        if ((periodic && request) || (!periodic && trigger)) begin
          running <= 1'b1;
          active <= 1'b1;
          count <= {CW{1'b0}};
        end else begin
          active <= 1'b0;
        end
      end else begin
        count <= count + {{(CW-1){1'b0}}, 1'b1};
        if (count == pulse_end) begin
          active <= 1'b0;
        end
        if (periodic ? (count == period_end) : (count == pulse_end)) begin
          // Back to back pulses in periodic mode keep the 4 ms rhythm
          running <= periodic && request;
          active <= periodic && request;
          count <= {CW{1'b0}};
        end else if (periodic && !request) begin
          running <= 1'b0;
          active <= 1'b0;
        end
      end
    end
  end

endmodule

/* File: testbench/fic_sva.sv */
// Port checker for the fault interrupt control
`timescale 1ns/1ps
module fic_sva #(
  parameter NFLAG = 8
) (
  input wire mclk,
  input wire resetn,
  input wire clk_en,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  input wire [NFLAG-1:0] event_src,
  input wire [NFLAG-1:0] live_flags,
  input wire dac_fault_pd,
  input wire output_fault_detect_off,
  input wire regulator_short_detect_off,
  input wire ch1_in_recovery,
  input wire ch2_in_recovery,
  input wire ch1_mute,
  input wire ch2_mute
);
  // ----------------------------------------
  // Sequences
  // ----------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);
  sequence s_rd(a);
    clk_en && reg_rd && reg_addr == a;
  endsequence
  // Long enough for the two-flop synchroniser and the output register
  sequence s_idle1;
    !ch1_in_recovery [*5];
  endsequence
  sequence s_idle2;
    !ch2_in_recovery [*5];
  endsequence
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_live_set;
    event_src[0] [*4] |=> live_flags[0];
  endproperty
  property p_live_clr;
    (event_src == 0) [*4] |=> (live_flags == 0);
  endproperty
  property p_mute1;
    s_idle1 |=> !ch1_mute;
  endproperty
  property p_mute2;
    s_idle2 |=> !ch2_mute;
  endproperty
  property p_det_off;
    bit v;
    (clk_en && reg_wr && reg_addr == 8'h43, v = reg_wdata[1]) |=> ##1 output_fault_detect_off == v;
  endproperty
  property p_reg_off;
    bit v;
    (clk_en && reg_wr && reg_addr == 8'h43, v = reg_wdata[0])
      |=> ##1 regulator_short_detect_off == v;
  endproperty
  property p_dac_sts;
    s_rd(8'h43) |=> reg_rdata[3] == $past(dac_fault_pd) && !reg_rdata[7];
  endproperty
  property p_rsvd_4b;
    s_rd(8'h4b) |=> reg_rdata[2:0] == 3'h0;
  endproperty
  a_live_set: assert property (p_live_set) else $error("live flag missed");
  a_live_clr: assert property (p_live_clr) else $error("live flag stuck");
  a_mute1: assert property (p_mute1) else $error("ch1 mute stuck");
  a_mute2: assert property (p_mute2) else $error("ch2 mute stuck");
  a_det_off: assert property (p_det_off) else $error("detect off wrong");
  a_reg_off: assert property (p_reg_off) else $error("regulator off wrong");
  a_dac_sts: assert property (p_dac_sts) else $error("status bit wrong");
  a_rsvd_4b: assert property (p_rsvd_4b) else $error("low bits not zero");
endmodule

/* File: testbench/fic_host_model.sv */
// Host side model that decodes the interrupt pin
`timescale 1ns/1ps
module fic_host_model (
  input wire mclk,
  input wire resetn,
  input wire line,
  input wire pol,
  output wire active,
  output reg [7:0] rises
);
  reg prev;
  // Active level follows the polarity the host programmed
  assign active = pol ? line : ~line;
  // Count assertions like a sampled host input; one edge per pulse
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      prev <= 1'b0;
      rises <= 8'h00;
    end else begin
      prev <= active;
      if (active && !prev) begin
        rises <= rises + 8'h01;
      end
    end
  end
endmodule

/* File: testbench/test_fault_interrupt_control.sv */
// Self-checking bench for the fault interrupt control
`timescale 1ns/1ps
module test_fault_interrupt_control;
  reg mclk, resetn, wr, rd, frd, gate, pwrup, r1, r2, arp, drp, pol, ce, osh, rsh;
  reg [7:0] addr, wd, ev, msk, d, r0;
  wire [7:0] rdata, frdata, live, rises;
  wire line, apd, dpd, doff, roff, m1, m2, act;
  integer bad_count, checks_done, n;
  // ----------------------------------------
  // Instances
  // ----------------------------------------
  // Short pulse and period keep the run brief
  fic_fault_ctrl #(.PULSE_CYC(10), .PERIOD_CYC(20)) DUT (
    .mclk(mclk), .resetn(resetn), .clk_en(ce), .reg_addr(addr), .reg_wdata(wd),
    .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .flag_rd(frd), .flag_rdata(frdata),
    .live_flags(live), .event_src(ev), .irq_mask(msk), .adc_fault_sel(8'h01),
    .dac_fault_sel(8'h02), .driver_gate_fault(gate), .output_short_fault(osh),
    .regulator_short(rsh), .dac_powering_up(pwrup), .ch1_in_recovery(r1),
    .ch2_in_recovery(r2), .adc_repower(arp), .dac_repower(drp),
    .interrupt_line_low(line), .adc_fault_pd(apd), .dac_fault_pd(dpd),
    .output_fault_detect_off(doff), .regulator_short_detect_off(roff),
    .ch1_mute(m1), .ch2_mute(m2));
  fic_host_model host (.mclk(mclk), .resetn(resetn), .line(line), .pol(pol),
    .active(act), .rises(rises));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task cmp(input string nm, input [7:0] e, input [7:0] g);
    checks_done = checks_done + 1;
    if (g !== e) begin
      bad_count = bad_count + 1;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task tk(input integer c);
    repeat (c) @(negedge mclk);
  endtask
  // Callers keep reserved bits at their reset values
  task wreg(input [7:0] a, input [7:0] v);
    @(negedge mclk);
    addr = a;
    wd = v;
    wr = 1;
    if (a == 8'h42) pol = v[7];
    @(negedge mclk);
    wr = 0;
  endtask
  task rreg(input [7:0] a);
    @(negedge mclk);
    addr = a;
    rd = 1;
    @(negedge mclk);
    rd = 0;
    d = rdata;
  endtask
  task rflag;
    @(negedge mclk);
    frd = 1;
    @(negedge mclk);
    frd = 0;
    d = frdata;
  endtask
  task cnt;
    n = 0;
    repeat (40) begin
      @(negedge mclk);
      n = n + act;
    end
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_regs;
    rreg(8'h42);
    cmp("cfg", 8'h00, d);
    rreg(8'h43);
    cmp("flt", 8'h50, d);
    rreg(8'h44);
    cmp("unmapped", 8'h00, d);
    wreg(8'h43, 8'h27);
    rreg(8'h43);
    cmp("flt", 8'h27, d);
    cmp("doff", 8'h01, doff);
    cmp("roff", 8'h01, roff);
    wreg(8'h43, 8'h50);
    wreg(8'h42, 8'hef);
    rreg(8'h42);
    cmp("cfg", 8'hef, d);
    wreg(8'h42, 8'h00);
    $display("regs done");
  endtask
  task t_latch;
    ev = 8'h01;
    tk(8);
    cmp("line", 8'h00, line);
    cmp("host", 8'h01, act);
    rflag;
    rflag;
    cmp("flag", 8'h01, d);
    ev = 8'h00;
    tk(8);
    cmp("line", 8'h00, line);
    rflag;
    rflag;
    cmp("flag", 8'h00, d);
    tk(4);
    cmp("line", 8'h01, line);
    msk = 8'h02;
    ev = 8'h02;
    tk(8);
    cmp("line", 8'h01, line);
    rflag;
    cmp("flag", 8'h02, d);
    wreg(8'h42, 8'h04);
    rflag;
    cmp("flag", 8'h00, d);
    ev = 8'h00;
    msk = 8'h00;
    tk(6);
    rflag;
    wreg(8'h42, 8'h80);
    tk(3);
    cmp("line", 8'h00, line);
    ev = 8'h01;
    tk(8);
    cmp("line", 8'h01, line);
    cmp("host", 8'h01, act);
    ev = 8'h00;
    tk(6);
    rflag;
    wreg(8'h42, 8'h20);
    ev = 8'h01;
    tk(8);
    cmp("line", 8'h00, line);
    ev = 8'h00;
    tk(8);
    cmp("line", 8'h01, line);
    rflag;
    wreg(8'h42, 8'h01);
    ev = 8'h01;
    tk(8);
    rflag;
    rflag;
    cmp("flag", 8'h00, d);
    cmp("line", 8'h01, line);
    ev = 8'h00;
    tk(4);
    $display("latch done");
  endtask
  task t_pulse;
    wreg(8'h42, 8'h40);
    ev = 8'h01;
    tk(4);
    ev = 8'h00;
    tk(30);
    cnt;
    cmp("high", 8'h14, n[7:0]);
    rflag;
    tk(25);
    cmp("line", 8'h01, line);
    wreg(8'h42, 8'h60);
    r0 = rises;
    ev = 8'h01;
    cnt;
    cmp("high", 8'h0a, n[7:0]);
    cmp("rises", 8'h01, rises - r0);
    ev = 8'h00;
    tk(6);
    rflag;
    $display("pulse done");
  endtask
  task t_pd;
    wreg(8'h42, 8'h10);
    ev = 8'h01;
    tk(8);
    cmp("apd", 8'h01, apd);
    ev = 8'h00;
    tk(8);
    cmp("apd", 8'h00, apd);
    msk = 8'h01;
    wreg(8'h42, 8'h08);
    ev = 8'h01;
    tk(8);
    cmp("apd", 8'h00, apd);
    msk = 8'h00;
    wreg(8'h42, 8'h12);
    ev = 8'h00;
    tk(8);
    cmp("apd", 8'h01, apd);
    arp = 1;
    tk(1);
    arp = 0;
    tk(4);
    cmp("apd", 8'h00, apd);
    ev = 8'h02;
    tk(8);
    cmp("dpd", 8'h01, dpd);
    ev = 8'h00;
    tk(8);
    rreg(8'h43);
    cmp("flt", 8'h58, d);
    drp = 1;
    tk(1);
    drp = 0;
    tk(4);
    cmp("dpd", 8'h00, dpd);
    rflag;
    wreg(8'h43, 8'h44);
    pwrup = 1;
    gate = 1;
    tk(8);
    cmp("dpd", 8'h00, dpd);
    wreg(8'h43, 8'h40);
    tk(8);
    cmp("dpd", 8'h01, dpd);
    gate = 0;
    tk(8);
    cmp("dpd", 8'h00, dpd);
    wreg(8'h43, 8'h42);
    gate = 1;
    osh = 1;
    tk(8);
    cmp("dpd", 8'h00, dpd);
    gate = 0;
    pwrup = 0;
    wreg(8'h43, 8'h40);
    tk(8);
    cmp("dpd", 8'h01, dpd);
    osh = 0;
    tk(8);
    cmp("dpd", 8'h00, dpd);
    wreg(8'h42, 8'h10);
    wreg(8'h43, 8'h51);
    rsh = 1;
    tk(8);
    cmp("apd", 8'h00, apd);
    wreg(8'h43, 8'h50);
    tk(4);
    cmp("apd", 8'h01, apd);
    rsh = 0;
    tk(8);
    cmp("apd", 8'h00, apd);
    $display("powerdown done");
  endtask
  task t_mute;
    wreg(8'h4b, 8'h10);
    r1 = 1;
    r2 = 1;
    tk(6);
    cmp("m1", 8'h01, m1);
    cmp("m2", 8'h00, m2);
    wreg(8'h4b, 8'h08);
    tk(4);
    cmp("m1", 8'h00, m1);
    cmp("m2", 8'h01, m2);
    r1 = 0;
    r2 = 0;
    tk(6);
    rreg(8'h4b);
    cmp("mute", 8'h08, d);
    ce = 0;
    wreg(8'h4b, 8'h10);
    ce = 1;
    rreg(8'h4b);
    cmp("frozen", 8'h08, d);
    $display("mute done");
  endtask
  // ----------------------------------------
  // Clock, sequence and watchdog
  // ----------------------------------------
  initial begin
    mclk = 0;
    forever #10 mclk = ~mclk;
  end
  initial begin
    resetn = 0;
    {wr, rd, frd, gate, pwrup, r1, r2, arp, drp, pol, osh, rsh} = 12'h000;
    ce = 1'b1;
    {addr, wd, ev, msk} = 32'h0000_0000;
    bad_count = 0;
    checks_done = 0;
    tk(8);
    resetn = 1;
    t_regs;
    t_latch;
    t_pulse;
    t_pd;
    t_mute;
    stop_test;
  end
  // Whole run is about five hundred cycles; allow twenty times that
  initial begin
    #200_000;
    bad_count = bad_count + 1;
    stop_test;
  end
endmodule
bind fic_fault_ctrl fic_sva #(.NFLAG(NFLAG)) u_sva (.mclk(mclk), .resetn(resetn),
  .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .event_src(event_src), .live_flags(live_flags),
  .dac_fault_pd(dac_fault_pd), .output_fault_detect_off(output_fault_detect_off),
  .regulator_short_detect_off(regulator_short_detect_off),
  .ch1_in_recovery(ch1_in_recovery), .ch2_in_recovery(ch2_in_recovery),
  .ch1_mute(ch1_mute), .ch2_mute(ch2_mute));
